/* cpu_condition_eval.v */
`timescale 1ns/1ps
module cpu_condition_eval
(
  // Condition code and flags
  input wire [3:0] conditionField,
  input wire [7:0] flags,
  // Decision
  output reg takeJump
);
`include "cpu_flags_regs.vh"
reg base;
always @*
begin
  // Only the upper four flag bits steer the decision.
  case (conditionField[2:0])
    3'h0: base = 1'b0;
    3'h7: base = flags[`BIT_CARRY];
    3'h6: base = flags[`BIT_ZERO];
    3'h5: base = flags[`BIT_SIGN];
    3'h4: base = flags[`BIT_OVERFLOW];
    3'h1: base = flags[`BIT_SIGN] ^ flags[`BIT_OVERFLOW];
    3'h2: base = flags[`BIT_ZERO] | (flags[`BIT_SIGN] ^ flags[`BIT_OVERFLOW]);
    3'h3: base = flags[`BIT_CARRY] | flags[`BIT_ZERO];
    default: base = 1'b0;
  endcase
  takeJump = conditionField[3] ^ base;
end
endmodule

/* cpu_flags_regs.vh */
`ifndef CPU_FLAGS_REGS_VH
`define CPU_FLAGS_REGS_VH
// ****************************************
// Status register location and layout.
// ****************************************
`define STATUS_ADDR 8'hd5
`define STATUS_RESET 8'h00
`define BIT_OVERFLOW 4
`define BIT_SIGN 5
`define BIT_ZERO 6
`define BIT_CARRY 7
// ****************************************
// Operation codes on opSel.
// ****************************************
`define OP_NONE 5'h00
`define OP_ADD 5'h01
`define OP_ADC 5'h02
`define OP_SUB 5'h03
`define OP_SBC 5'h04
`define OP_CMP 5'h05
`define OP_INC 5'h06
`define OP_DEC 5'h07
`define OP_AND 5'h08
`define OP_OR 5'h09
`define OP_XOR 5'h0a
`define OP_COM 5'h0b
`define OP_MASK_TEST 5'h0c
`define OP_INV_MASK_TEST 5'h0d
`define OP_ROT_LEFT 5'h0e
`define OP_ROT_LEFT_CARRY 5'h0f
`define OP_ROT_RIGHT 5'h10
`define OP_ROT_RIGHT_CARRY 5'h11
`define OP_ARITH_SHIFT_RIGHT 5'h12
`define OP_SET_CARRY 5'h13
`define OP_CLEAR_CARRY 5'h14
`define OP_INVERT_CARRY 5'h15
// ****************************************
// Addressing modes and condition codes.
// ****************************************
`define MODE_SHORT_INDEXED 2'h0
`define MODE_LONG_INDEXED 2'h1
`define MODE_RELATIVE 2'h2
`define LONG_OFFSET_MAX 13'h1fff
`define COND_NEVER 4'h0
`define COND_ALWAYS 4'h8
`endif

/* cpu_status_checker.sv */
`timescale 1ns/1ps
`include "cpu_flags_regs.vh"
module cpu_status_checker
(
  // All ports of the flag block
  input wire sys_clk, resetn, opValid, statusWrite, resultWrite, jumpTaken, pairOperand, operandValid,
  input wire [4:0] opSel,
  input wire [7:0] dstOperand, srcOperand, statusAddr, statusWrData, statusRdData, resultData, registerAddr,
  input wire [3:0] conditionField, workRegIndex,
  input wire [1:0] addrMode,
  input wire [15:0] baseAddr, effectiveAddr,
  input wire [12:0] offsetValue
);
  // ****************************************
  // Delayed reset and captured inputs.
  // ****************************************
  reg [1:0] rs;
  reg [7:0] dq, sq, wq, tq;
  reg [15:0] bq;
  reg [12:0] oq;
  // The block keeps its own reset for two edges, so checking waits as long.
  always @(posedge sys_clk or negedge resetn)
    if (!resetn)
      rs <= 2'b00;
    else
      rs <= {rs[0], 1'b1};
  always @(posedge sys_clk)
  begin
    dq <= dstOperand;
    sq <= srcOperand;
    wq <= statusWrData;
    tq <= statusRdData;
    bq <= baseAddr;
    oq <= offsetValue;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rs[1]);
  AST_ADD: assert property (opValid && opSel == `OP_ADD |=> {statusRdData[7], resultData} == dq + sq)
    else $error("add result or carry wrong");
  AST_SUB_V: assert property (opValid && opSel == `OP_SUB |=>
    statusRdData[4] == ((dq[7] ^ sq[7]) & (dq[7] ^ resultData[7]))) else $error("subtract overflow wrong");
  AST_LOGIC_V: assert property (opValid && opSel >= `OP_AND && opSel <= `OP_COM |=> !statusRdData[4])
    else $error("logic left overflow set");
  AST_SIGN: assert property (resultWrite |-> statusRdData[5] == resultData[7])
    else $error("sign wrong");
  AST_ZERO: assert property (resultWrite |-> statusRdData[6] == (resultData == 8'h00))
    else $error("zero wrong");
  AST_RL: assert property (opValid && opSel == `OP_ROT_LEFT |=>
    resultData == {dq[6:0], dq[7]} && statusRdData[7] == dq[7]) else $error("rotate left wrong");
  AST_ASR: assert property (opValid && opSel == `OP_ARITH_SHIFT_RIGHT |=>
    resultData == {dq[7], dq[7:1]} && statusRdData[7] == dq[0]) else $error("arithmetic shift wrong");
  AST_INV_C: assert property (opValid && opSel == `OP_INVERT_CARRY && !statusWrite |=>
    statusRdData == (tq ^ 8'h80)) else $error("carry invert wrong");
  AST_WRITE: assert property (statusWrite && statusAddr == `STATUS_ADDR && !opValid |=> statusRdData == wq)
    else $error("status write lost");
  AST_NEVER: assert property (conditionField == `COND_NEVER |=> !jumpTaken)
    else $error("never condition jumped");
  AST_LONG: assert property (addrMode == `MODE_LONG_INDEXED |=> effectiveAddr == bq + {3'b000, oq})
    else $error("long index address wrong");
endmodule
bind cpu_status_flags cpu_status_checker chk (.sys_clk, .resetn, .opValid, .statusWrite, .resultWrite,
  .jumpTaken, .pairOperand, .operandValid, .opSel, .dstOperand, .srcOperand, .statusAddr, .statusWrData,
  .statusRdData, .resultData, .registerAddr, .conditionField, .workRegIndex, .addrMode, .baseAddr,
  .effectiveAddr, .offsetValue);

/* cpu_status_flags.v */
// Notes on behaviour
// - Eight-bit status, bits 4-7 are conditions.
// - Plain writes may set or clear status.
// - Flag update colliding with write is undefined.
// - Overflow set beyond +127 or -128.
// - Logic operations clear overflow.
// - Sign copies result MSB.
// - Zero set when result is zero.
// - Carry on carry out or borrow.
// - Shifts leave last shifted-out bit in carry.
// - Set, clear, invert carry operations.
// - Registers 0-255 or working 0-15.
// - Pairs use even addresses only.
// - Short index adds signed -128..+127.
// - Long index adds unsigned 0..8191.
// - Relative adds signed offset to next address.
// - Rotates plain, through carry, arithmetic shift.
// - Mask test and inverted mask test.
// - Condition 0000 never, 1000 always.
`timescale 1ns/1ps
module cpu_status_flags
(
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Operation request
  input wire opValid,
  input wire [4:0] opSel,
  input wire [7:0] dstOperand,
  input wire [7:0] srcOperand,
  // Status register access
  input wire statusWrite,
  input wire [7:0] statusAddr,
  input wire [7:0] statusWrData,
  output reg [7:0] statusRdData,
  // Operation result
  output reg [7:0] resultData,
  output reg resultWrite,
  // Conditional jump
  input wire [3:0] conditionField,
  output reg jumpTaken,
  // Operand decoding
  input wire [1:0] addrMode,
  input wire [3:0] workRegIndex,
  input wire pairOperand,
  input wire [7:0] registerAddr,
  input wire [15:0] baseAddr,
  input wire [12:0] offsetValue,
  output reg [15:0] effectiveAddr,
  output reg operandValid
);
`include "cpu_flags_regs.vh"
// ****************************************
// Reset release.
// ****************************************
reg rstSync1_q;
reg rstSync2_q;
always @(posedge sys_clk or negedge resetn)
begin
  if (!resetn)
  begin
    rstSync1_q <= 1'b0;
    rstSync2_q <= 1'b0;
  end
  else
  begin
    rstSync1_q <= 1'b1;
    rstSync2_q <= rstSync1_q;
  end
end
wire rstN = rstSync2_q;
// ****************************************
// Datapath and flag computation.
// ****************************************
reg [7:0] status_q;
reg [7:0] status_d;
reg [7:0] res;
reg [8:0] wide;
reg cin;
reg writesResult;
reg newV;
reg newC;
reg updC;
reg updV;
reg updSZ;
wire carryIn = status_q[`BIT_CARRY];
wire statusHit = statusWrite && (statusAddr == `STATUS_ADDR);
always @*
begin
  res = dstOperand;
  wide = 9'h000;
  cin = 1'b0;
  newV = 1'b0;
  newC = carryIn;
  updC = 1'b0;
  updV = 1'b0;
  updSZ = 1'b0;
  writesResult = 1'b0;
  case (opSel)
    `OP_ADD, `OP_ADC, `OP_INC:
    begin
      cin = (opSel == `OP_ADC) ? carryIn : 1'b0;
      wide = {1'b0, dstOperand} + ((opSel == `OP_INC) ? 9'h001 : {1'b0, srcOperand}) + {8'h00, cin};
      res = wide[7:0];
      newV = (dstOperand[7] == ((opSel == `OP_INC) ? 1'b0 : srcOperand[7])) && (res[7] != dstOperand[7]);
      newC = wide[8];
      updC = (opSel != `OP_INC);
      updV = 1'b1;
      updSZ = 1'b1;
      writesResult = 1'b1;
    end
    `OP_SUB, `OP_SBC, `OP_CMP, `OP_DEC:
    begin
      cin = (opSel == `OP_SBC) ? carryIn : 1'b0;
      wide = {1'b0, dstOperand} - ((opSel == `OP_DEC) ? 9'h001 : {1'b0, srcOperand}) - {8'h00, cin};
      res = wide[7:0];
      newV = (dstOperand[7] != ((opSel == `OP_DEC) ? 1'b0 : srcOperand[7])) && (res[7] != dstOperand[7]);
      newC = wide[8];
      updC = (opSel != `OP_DEC);
      updV = 1'b1;
      updSZ = 1'b1;
      writesResult = (opSel != `OP_CMP);
    end
    `OP_AND, `OP_OR, `OP_XOR, `OP_COM, `OP_MASK_TEST, `OP_INV_MASK_TEST:
    begin
      case (opSel)
        `OP_AND: res = dstOperand & srcOperand;
        `OP_OR: res = dstOperand | srcOperand;
        `OP_XOR: res = dstOperand ^ srcOperand;
        `OP_COM: res = ~dstOperand;
        `OP_MASK_TEST: res = dstOperand & srcOperand;
        default: res = ~dstOperand & srcOperand;
      endcase
      newV = 1'b0;
      updV = 1'b1;
      updSZ = 1'b1;
      writesResult = (opSel != `OP_MASK_TEST) && (opSel != `OP_INV_MASK_TEST);
    end
    `OP_ROT_LEFT, `OP_ROT_LEFT_CARRY, `OP_ROT_RIGHT, `OP_ROT_RIGHT_CARRY, `OP_ARITH_SHIFT_RIGHT:
    begin
      case (opSel)
        `OP_ROT_LEFT: res = {dstOperand[6:0], dstOperand[7]};
        `OP_ROT_LEFT_CARRY: res = {dstOperand[6:0], carryIn};
        `OP_ROT_RIGHT: res = {dstOperand[0], dstOperand[7:1]};
        `OP_ROT_RIGHT_CARRY: res = {carryIn, dstOperand[7:1]};
        default: res = {dstOperand[7], dstOperand[7:1]};
      endcase
      newC = (opSel == `OP_ROT_LEFT || opSel == `OP_ROT_LEFT_CARRY) ? dstOperand[7] : dstOperand[0];
      newV = (res[7] != dstOperand[7]);
      updC = 1'b1;
      updV = 1'b1;
      updSZ = 1'b1;
      writesResult = 1'b1;
    end
    `OP_SET_CARRY:
    begin
      newC = 1'b1;
      updC = 1'b1;
    end
    `OP_CLEAR_CARRY:
    begin
      newC = 1'b0;
      updC = 1'b1;
    end
    `OP_INVERT_CARRY:
    begin
      newC = ~carryIn;
      updC = 1'b1;
    end
    default:
    begin
      res = dstOperand;
    end
  endcase
end
always @*
begin
  status_d = statusHit ? statusWrData : status_q;
  // Flag update also lands; the mix is unpredictable to software.
  if (opValid)
  begin
    if (updC)
      status_d[`BIT_CARRY] = newC;
    if (updV)
      status_d[`BIT_OVERFLOW] = newV;
    if (updSZ)
    begin
      status_d[`BIT_SIGN] = res[7];
      status_d[`BIT_ZERO] = (res == 8'h00);
    end
  end
end
// ****************************************
// Operand range decoding.
// ****************************************
reg [15:0] ea;
reg eaOk;
always @*
begin
  ea = 16'h0000;
  eaOk = pairOperand ? (~registerAddr[0] & ~workRegIndex[0]) : 1'b1;
  case (addrMode)
    `MODE_SHORT_INDEXED: ea = baseAddr + {{8{offsetValue[7]}}, offsetValue[7:0]};
    `MODE_LONG_INDEXED: ea = baseAddr + {3'b000, offsetValue & `LONG_OFFSET_MAX};
    `MODE_RELATIVE: ea = baseAddr + {{8{offsetValue[7]}}, offsetValue[7:0]};
    default: ea = baseAddr;
  endcase
end
wire takeJump;
cpu_condition_eval condEval
(
  .conditionField(conditionField),
  .flags(status_q),
  .takeJump(takeJump)
);
// ****************************************
// Registers.
// ****************************************
always @(posedge sys_clk or negedge rstN)
begin
  if (!rstN)
  begin
    status_q <= `STATUS_RESET;
    statusRdData <= `STATUS_RESET;
    resultData <= 8'h00;
    resultWrite <= 1'b0;
    jumpTaken <= 1'b0;
    effectiveAddr <= 16'h0000;
    operandValid <= 1'b0;
  end
  else
  begin
    status_q <= status_d;
    statusRdData <= status_d;
    resultData <= res;
    resultWrite <= opValid & writesResult;
    jumpTaken <= takeJump;
    effectiveAddr <= ea;
    operandValid <= eaOk;
  end
end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "cpu_flags_regs.vh"
module tb_top;
  // ****************************************
  // Stimulus, tasks and sequence.
  // ****************************************
  reg sys_clk = 0, resetn = 0, opValid = 0, statusWrite = 0, pairOperand = 0;
  reg [4:0] opSel = 0;
  reg [7:0] dstOperand = 0, srcOperand = 0, statusAddr = 0, statusWrData = 0, registerAddr = 0;
  reg [3:0] conditionField = 0, workRegIndex = 0;
  reg [1:0] addrMode = 0;
  reg [15:0] baseAddr = 0;
  reg [12:0] offsetValue = 0;
  wire [7:0] statusRdData, resultData;
  wire [15:0] effectiveAddr;
  wire resultWrite, jumpTaken, operandValid;
  integer n_fail = 0, compares = 0;
  always #20 sys_clk = ~sys_clk;
  cpu_status_flags dut (.sys_clk, .resetn, .opValid, .opSel, .dstOperand, .srcOperand, .statusWrite,
    .statusAddr, .statusWrData, .statusRdData, .resultData, .resultWrite, .conditionField, .jumpTaken,
    .addrMode, .workRegIndex, .pairOperand, .registerAddr, .baseAddr, .offsetValue, .effectiveAddr,
    .operandValid);
  task ck(input [8*6:1] nm, input [15:0] e, input [15:0] g);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // Outputs are registered, so each request is checked one edge later.
  task op(input [4:0] s, input [7:0] d, input [7:0] r, input [7:0] er, input [7:0] es, input [7:0] m);
  begin
    @(negedge sys_clk);
    opValid = 1;
    opSel = s;
    dstOperand = d;
    srcOperand = r;
    @(negedge sys_clk);
    opValid = 0;
    ck("status", es & m, statusRdData & m);
    ck("write", (s != `OP_NONE && s <= `OP_COM && s != `OP_CMP) ||
      (s >= `OP_ROT_LEFT && s <= `OP_ARITH_SHIFT_RIGHT), resultWrite);
    if (s < `OP_MASK_TEST || (s > `OP_INV_MASK_TEST && s < `OP_SET_CARRY))
      ck("result", er, resultData);
  end
  endtask
  task wr(input [7:0] a, input [7:0] v, input [7:0] es);
  begin
    @(negedge sys_clk);
    statusWrite = 1;
    statusAddr = a;
    statusWrData = v;
    @(negedge sys_clk);
    statusWrite = 0;
    ck("status", es, statusRdData);
  end
  endtask
  task jc(input [3:0] c, input e);
  begin
    @(negedge sys_clk);
    conditionField = c;
    @(negedge sys_clk);
    ck("jump", e, jumpTaken);
  end
  endtask
  task am(input [1:0] md, input p, input [3:0] w, input [7:0] ra, input [15:0] b, input [12:0] o,
    input [15:0] ee, input ev);
  begin
    @(negedge sys_clk);
    addrMode = md;
    pairOperand = p;
    workRegIndex = w;
    registerAddr = ra;
    baseAddr = b;
    offsetValue = o;
    @(negedge sys_clk);
    ck("addr", ee, effectiveAddr);
    ck("valid", ev, operandValid);
  end
  endtask
  task close_out;
  begin
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (2) @(negedge sys_clk);
    resetn = 1;
    repeat (3) @(negedge sys_clk);
    wr(8'hd5, 8'h0f, 8'h0f);
    wr(8'hd4, 8'hff, 8'h0f);
    jc(`COND_NEVER, 0);
    jc(`COND_ALWAYS, 1);
    jc(4'h7, 0);
    jc(4'hf, 1);
    op(`OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h3f, 8'hff);
    op(`OP_ADD, 8'hff, 8'h01, 8'h00, 8'hcf, 8'hff);
    op(`OP_SUB, 8'h00, 8'h01, 8'hff, 8'haf, 8'hff);
    op(`OP_SUB, 8'h80, 8'h01, 8'h7f, 8'h1f, 8'hff);
    op(`OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h4f, 8'hff);
    op(`OP_SET_CARRY, 0, 0, 0, 8'hcf, 8'hff);
    op(`OP_CLEAR_CARRY, 0, 0, 0, 8'h4f, 8'hff);
    op(`OP_INVERT_CARRY, 0, 0, 0, 8'hcf, 8'hff);
    op(`OP_ROT_LEFT, 8'h81, 0, 8'h03, 8'h9f, 8'hff);
    op(`OP_ARITH_SHIFT_RIGHT, 8'h81, 0, 8'hc0, 8'haf, 8'hff);
    op(`OP_ROT_RIGHT, 8'h01, 0, 8'h80, 8'hbf, 8'hff);
    op(`OP_ROT_RIGHT_CARRY, 8'h02, 0, 8'h81, 8'h3f, 8'hff);
    op(`OP_ROT_LEFT_CARRY, 8'h80, 0, 8'h00, 8'hdf, 8'hff);
    jc(4'h7, 1);
    op(`OP_MASK_TEST, 8'h0f, 8'hf0, 0, 8'h40, 8'h40);
    op(`OP_INV_MASK_TEST, 8'h0f, 8'hf0, 0, 8'h00, 8'h40);
    op(`OP_INV_MASK_TEST, 8'hf0, 8'hf0, 0, 8'h40, 8'h40);
    am(`MODE_LONG_INDEXED, 1, 4'h2, 8'h10, 16'h1000, 13'h1fff, 16'h2fff, 1);
    am(`MODE_SHORT_INDEXED, 1, 4'h2, 8'h10, 16'h1000, 13'h0080, 16'h0f80, 1);
    am(`MODE_RELATIVE, 0, 4'h0, 8'h00, 16'h0100, 13'h00ff, 16'h00ff, 1);
    am(`MODE_LONG_INDEXED, 1, 4'h2, 8'h03, 0, 0, 0, 0);
    am(`MODE_LONG_INDEXED, 1, 4'h1, 8'hfe, 0, 0, 0, 0);
    am(`MODE_LONG_INDEXED, 0, 4'hf, 8'hff, 0, 0, 0, 1);
    op(`OP_ADC, 8'h10, 8'h20, 8'h31, 8'h0f, 8'hff);
    op(`OP_CMP, 8'h05, 8'h10, 8'hf5, 8'haf, 8'hff);
    op(`OP_SBC, 8'h10, 8'h05, 8'h0a, 8'h0f, 8'hff);
    op(`OP_INC, 8'h7f, 0, 8'h80, 8'h3f, 8'hff);
    op(`OP_DEC, 8'h80, 0, 8'h7f, 8'h1f, 8'hff);
    jc(4'h4, 1);
    jc(4'hc, 0);
    op(`OP_COM, 8'h0f, 0, 8'hf0, 8'h2f, 8'hff);
    jc(4'h5, 1);
    jc(4'hd, 0);
    op(`OP_OR, 8'h80, 8'h01, 8'h81, 8'h2f, 8'hff);
    op(`OP_XOR, 8'h5a, 8'h5a, 8'h00, 8'h4f, 8'hff);
    jc(4'h6, 1);
    jc(4'he, 0);
    // A reset in mid-run must bring the status back to its reset value.
    @(negedge sys_clk);
    resetn = 0;
    @(negedge sys_clk);
    ck("status", `STATUS_RESET, statusRdData);
    ck("jump", 0, jumpTaken);
    resetn = 1;
    repeat (3) @(negedge sys_clk);
    wr(8'hd5, 8'ha5, 8'ha5);
    jc(4'h7, 1);
    close_out;
  end
endmodule
